// ==== supply_detect_pkg.sv ====
`default_nettype none
package supply_detect_pkg;

    // register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_MASTER = 3'h1;
    localparam logic [2:0] ADDR_FLAGS = 3'h2;
    localparam logic [2:0] ADDR_ENABLES = 3'h3;
    localparam logic [2:0] ADDR_PRIORITIES = 3'h4;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h5;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;

    // control register field positions
    localparam int CTL_DIR_BIT = 7;
    localparam int CTL_STABLE_BIT = 5;
    localparam int CTL_ENABLE_BIT = 4;
    localparam int CTL_LEVEL_LSB = 0;
    localparam int LEVEL_W = 4;
    localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;

    // interrupt-related bit positions
    localparam int DET_BIT = 2;
    localparam int GIE_BIT = 7;

    // writable masks and reset values
    localparam logic [7:0] CTL_WR_MASK = 8'h9F;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] FLAGS_IMPL = 8'hDF;

    // local status/mask bits: 0 trip event, 1 reference became stable
    localparam int EV_TRIP = 0;
    localparam int EV_STABLE = 1;
    localparam logic [7:0] EV_IMPL = 8'h03;

    // settle interval, timed by a free running reference tick
    localparam int SETTLE_US = 20;
    localparam int TICK_NS = 1000;

    typedef struct packed {
        logic trip_direction_select;
        logic detector_power_enable;
        logic [3:0] trip_level_select;
    } detect_ctl_t;

endpackage : supply_detect_pkg
`default_nettype wire

// ==== settle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// counts reference ticks after enable; clock frequency does not matter
module settle_timer #(
    parameter int TICKS = 20
) (
    input wire logic core_clk_i, // system clock
    input wire logic rst_i, // async reset, high
    input wire logic run_i, // detector enabled
    input wire logic tick_i, // one-cycle pulse per reference tick
    output logic done_o // interval expired
);
    logic [15:0] count;

    // restart whenever the detector is disabled
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= 16'h0000;
            done_o <= 1'b0;
        end else if (!run_i) begin
            count <= 16'h0000;
            done_o <= 1'b0;
        end else if (tick_i && !done_o) begin
            if (count == 16'(TICKS - 1)) begin
                done_o <= 1'b1;
            end
            count <= count + 16'h0001;
        end
    end
endmodule : settle_timer
`default_nettype wire

// ==== supply_level_detector.sv ====
// Behaviour
// - enable bit powers comparator and divider
// - reference shareable with other on-chip users
// - wait settle interval after reference re-enable
// - settle interval independent of system clock
// - event flag disarmed until reference stable
// - excursions during settling may go unflagged
// - detector keeps running during sleep
// - trip in sleep sets flag, wakes
// - vector only if global enable set
// - reset disables detector, clears registers
// - control register bit layout as specified
// - flag, enable, priority at bit two
// - unimplemented bits read as zero
// - direction selects falling or rising trip
// - stable flag read-only, gates interrupts
// - level all ones selects external pin
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module supply_level_detector #(
    parameter int SETTLE_TICKS = supply_detect_pkg::SETTLE_US * 1000 / supply_detect_pkg::TICK_NS
) (
    input wire logic core_clk_i, // 125 MHz system clock
    input wire logic rst_i, // async device reset, high
    input wire logic [2:0] addr_i, // register index
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic ref_tick_i, // async tick from a clock-independent oscillator
    input wire logic ref_shared_i, // another on-chip user keeps the reference on
    input wire logic ref_ready_i, // async: analog reference reports stable
    input wire logic below_divider_i, // async comparator: supply below divider tap
    input wire logic below_external_i, // async comparator: supply below external pin level
    input wire logic sleep_i, // device is asleep
    output logic analog_enable_o, // powers comparator and divider
    output logic reference_enable_o, // powers the shared reference
    output logic external_select_o, // comparator takes external detect input
    output logic [3:0] tap_select_o, // divider tap
    output logic wake_o, // wake request from sleep
    output logic vector_o, // take the interrupt vector on wake
    output logic irq_high_o, // interrupt, high priority
    output logic irq_low_o, // interrupt, low priority
    output logic irq_o // local interrupt from status and mask
);
    supply_detect_pkg::detect_ctl_t ctl;
    logic [7:0] master;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] priorities;
    logic [7:0] ev_status;
    logic [7:0] ev_mask;
    logic [2:0] tick_sync;
    logic [2:0] ready_sync;
    logic [2:0] div_sync;
    logic [2:0] ext_sync;
    logic tick_seen;
    logic tick_pulse;
    logic ready_lvl;
    logic below_lvl;
    logic settle_done;
    logic stable;
    logic stable_q;
    logic below_q;
    logic trip;
    logic wr_flags;
    logic [7:0] read_mux;

    // a level counts once the second and third stages agree
    function automatic logic agreed(input logic [2:0] s, input logic prev);
        agreed = (s[1] == s[2]) ? s[2] : prev;
    endfunction : agreed

    function automatic logic hit(input logic [2:0] idx);
        hit = wr_i && (addr_i == idx);
    endfunction : hit

    // the detector's own interrupt source, flag and enable at bit two;
    // shared by the wake, vector and both priority lines
    function automatic logic det_pending(input logic [7:0] f, input logic [7:0] e);
        det_pending = f[supply_detect_pkg::DET_BIT] && e[supply_detect_pkg::DET_BIT];
    endfunction : det_pending

    // three stage synchronisers for asynchronous analog and tick inputs
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_sync <= 3'h0;
            ready_sync <= 3'h0;
            div_sync <= 3'h0;
            ext_sync <= 3'h0;
        end else begin
            tick_sync <= {tick_sync[1:0], ref_tick_i};
            ready_sync <= {ready_sync[1:0], ref_ready_i};
            div_sync <= {div_sync[1:0], below_divider_i};
            ext_sync <= {ext_sync[1:0], below_external_i};
        end
    end

    // filtered tick level; its rising edge below gives
    // one pulse per reference period, whatever the clock
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_seen <= 1'b0;
        end else begin
            tick_seen <= agreed(tick_sync, tick_seen);
        end
    end

    // filtered reference report; a one-cycle glitch
    // on the analog side does not reach the stable flag
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_lvl <= 1'b0;
        end else begin
            ready_lvl <= agreed(ready_sync, ready_lvl);
        end
    end

    // filtered comparator level from whichever input the level selects;
    // a change of source can show one stale cycle, which the trip tolerates
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            below_lvl <= 1'b0;
        end else if (ctl.trip_level_select == supply_detect_pkg::LEVEL_EXTERNAL) begin
            below_lvl <= agreed(ext_sync, below_lvl);
        end else begin
            below_lvl <= agreed(div_sync, below_lvl);
        end
    end
    assign tick_pulse = agreed(tick_sync, tick_seen) && !tick_seen;

    // settle interval counted on reference ticks, not system cycles
    settle_timer #(
        .TICKS(SETTLE_TICKS)
    ) u_settle (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .run_i(ctl.detector_power_enable),
        .tick_i(tick_pulse),
        .done_o(settle_done)
    );

    // stable needs both the interval and the reference's own report
    assign stable = settle_done && ready_lvl && ctl.detector_power_enable;

    // falling mode trips at or below, rising mode at or above
    assign trip = stable && (ctl.trip_direction_select ? !below_lvl : below_lvl);

    // decoded in place: a function in a continuous assignment would not
    // be re-evaluated when the strobe or the index changes
    assign wr_flags = wr_i && (addr_i == supply_detect_pkg::ADDR_FLAGS);

    // control register; stable flag and bit 6 are not writable
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl <= '0;
        end else if (hit(supply_detect_pkg::ADDR_CONTROL)) begin
            ctl.trip_direction_select <= wdata_i[supply_detect_pkg::CTL_DIR_BIT];
            ctl.detector_power_enable <= wdata_i[supply_detect_pkg::CTL_ENABLE_BIT];
            ctl.trip_level_select <= wdata_i[supply_detect_pkg::CTL_LEVEL_LSB +: 4];
        end
    end

    // master control; bit 7 decides whether a wake also
    // takes the interrupt vector or lets code run on
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            master <= supply_detect_pkg::REG_RESET;
        end else if (hit(supply_detect_pkg::ADDR_MASTER)) begin
            master <= wdata_i;
        end
    end

    // interrupt enables; the bit that does not exist
    // is masked on write so it can never read back as one
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enables <= supply_detect_pkg::REG_RESET;
        end else if (hit(supply_detect_pkg::ADDR_ENABLES)) begin
            enables <= wdata_i & supply_detect_pkg::FLAGS_IMPL;
        end
    end

    // interrupt priorities; same layout as the enables,
    // a set bit steers the source to the high line
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            priorities <= supply_detect_pkg::REG_RESET;
        end else if (hit(supply_detect_pkg::ADDR_PRIORITIES)) begin
            priorities <= wdata_i & supply_detect_pkg::FLAGS_IMPL;
        end
    end

    // local event mask; only the two event bits are kept,
    // so unused status bits can never raise the local line
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_mask <= supply_detect_pkg::REG_RESET;
        end else if (hit(supply_detect_pkg::ADDR_IRQ_MASK)) begin
            ev_mask <= wdata_i & supply_detect_pkg::EV_IMPL;
        end
    end

    // flag register: sticky trip bit, a trip beats a same-cycle clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags <= supply_detect_pkg::REG_RESET;
        end else begin
            if (wr_flags) flags <= wdata_i & supply_detect_pkg::FLAGS_IMPL;
            if (trip) flags[supply_detect_pkg::DET_BIT] <= 1'b1;
        end
    end

    // one-cycle delays, so that each event is recorded once on its rising
    // edge rather than on every cycle that it lasts
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stable_q <= 1'b0;
            below_q <= 1'b0;
        end else begin
            stable_q <= stable;
            below_q <= trip;
        end
    end

    // local event status: write one to clear, set wins
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_status <= supply_detect_pkg::REG_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (hit(supply_detect_pkg::ADDR_IRQ_STATUS) && wdata_i[i]) ev_status[i] <= 1'b0;
            end
            if (trip && !below_q) ev_status[supply_detect_pkg::EV_TRIP] <= 1'b1;
            if (stable && !stable_q) ev_status[supply_detect_pkg::EV_STABLE] <= 1'b1;
        end
    end

    // read mux; unimplemented bits are zero
    always_comb begin
        read_mux = 8'h00;
        case (addr_i)
            supply_detect_pkg::ADDR_CONTROL: begin
                read_mux[supply_detect_pkg::CTL_DIR_BIT] = ctl.trip_direction_select;
                read_mux[supply_detect_pkg::CTL_STABLE_BIT] = stable;
                read_mux[supply_detect_pkg::CTL_ENABLE_BIT] = ctl.detector_power_enable;
                read_mux[supply_detect_pkg::CTL_LEVEL_LSB +: 4] = ctl.trip_level_select;
            end
            supply_detect_pkg::ADDR_MASTER: read_mux = master;
            supply_detect_pkg::ADDR_FLAGS: read_mux = flags;
            supply_detect_pkg::ADDR_ENABLES: read_mux = enables;
            supply_detect_pkg::ADDR_PRIORITIES: read_mux = priorities;
            supply_detect_pkg::ADDR_IRQ_STATUS: read_mux = ev_status;
            supply_detect_pkg::ADDR_IRQ_MASK: read_mux = ev_mask;
            default: read_mux = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? read_mux : 8'h00;
        end
    end

    // comparator and divider power follow the enable bit
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_enable_o <= 1'b0;
        end else begin
            analog_enable_o <= ctl.detector_power_enable;
        end
    end

    // the reference stays on while any user needs it, so its ready
    // report may already be high when the detector is enabled
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reference_enable_o <= 1'b0;
        end else begin
            reference_enable_o <= ctl.detector_power_enable || ref_shared_i;
        end
    end

    // comparator input select and divider tap follow the level field
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            external_select_o <= 1'b0;
            tap_select_o <= 4'h0;
        end else begin
            external_select_o <=
                (ctl.trip_level_select == supply_detect_pkg::LEVEL_EXTERNAL);
            tap_select_o <= ctl.trip_level_select;
        end
    end

    // wake request while asleep and the detector's source is pending;
    // the flag logic runs unchanged in sleep, so no extra path is needed
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= sleep_i && det_pending(flags, enables);
        end
    end

    // vector only with the global enable;
    // otherwise execution simply continues in sequence
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            vector_o <= 1'b0;
        end else begin
            vector_o <= det_pending(flags, enables) &&
                master[supply_detect_pkg::GIE_BIT];
        end
    end

    // the priority bit steers the pending source to one of two lines
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_high_o <= 1'b0;
            irq_low_o <= 1'b0;
        end else begin
            irq_high_o <= det_pending(flags, enables) &&
                priorities[supply_detect_pkg::DET_BIT];
            irq_low_o <= det_pending(flags, enables) &&
                !priorities[supply_detect_pkg::DET_BIT];
        end
    end

    // local level interrupt from the event status and its mask
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ev_status & ev_mask);
        end
    end
endmodule : supply_level_detector
`default_nettype wire

// ==== supply_detect_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module supply_detect_asserts (
    input wire logic core_clk_i, // clock
    input wire logic rst_i, // async reset
    input wire logic [2:0] addr_i, // index
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [7:0] rdata_o, // read data
    input wire logic sleep_i, // asleep
    input wire logic ref_shared_i, // other reference user
    input wire logic analog_enable_o, // analog power
    input wire logic reference_enable_o, // reference power
    input wire logic external_select_o, // pin select
    input wire logic [3:0] tap_select_o, // divider tap
    input wire logic wake_o, // wake request
    input wire logic vector_o, // vector taken
    input wire logic irq_high_o, // high irq
    input wire logic irq_low_o // low irq
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // a lone control write lands on the analog outputs two edges later
    sequence ctl_wr_s;
        (wr_i && addr_i == 3'h0) ##1 !(wr_i && addr_i == 3'h0);
    endsequence
    unmapped_read_a: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    ctl_bit6_a: assert property (rd_i && addr_i == 3'h0 |=> !rdata_o[6])
        else $error("control bit 6 reads one");
    flag_bit5_a: assert property (rd_i && addr_i inside {3'h2, 3'h3, 3'h4} |=> !rdata_o[5])
        else $error("irq register bit 5 reads one");
    enable_follow_a: assert property (ctl_wr_s |=> analog_enable_o == $past(wdata_i[4], 2))
        else $error("analog enable does not follow control");
    tap_follow_a: assert property (ctl_wr_s |=> tap_select_o == $past(wdata_i[3:0], 2))
        else $error("tap does not follow level");
    property ref_share_p;
        !$past(rst_i) |-> reference_enable_o == (analog_enable_o || $past(ref_shared_i));
    endproperty
    ref_share_a: assert property (ref_share_p)
        else $error("reference power not enable or shared user");
    ext_select_a: assert property (external_select_o == (tap_select_o == 4'hF))
        else $error("external select mismatch");
    wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
        else $error("wake outside sleep");
    vector_gate_a: assert property (vector_o |-> (irq_high_o || irq_low_o))
        else $error("vector without pending event");
    prio_excl_a: assert property (!(irq_high_o && irq_low_o))
        else $error("both priorities raised");
    cover property (wake_o);
    cover property (vector_o);
    cover property ($rose(analog_enable_o));
endmodule : supply_detect_asserts
bind supply_level_detector supply_detect_asserts supply_detect_asserts_i (.core_clk_i, .rst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_i, .ref_shared_i, .analog_enable_o,
    .reference_enable_o, .external_select_o, .tap_select_o, .wake_o, .vector_o, .irq_high_o,
    .irq_low_o);
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module testbench;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic tick = 1'b0;
    logic shared = 1'b0;
    logic ready = 1'b0;
    logic below = 1'b0;
    logic below_ext = 1'b0;
    logic sleep_i = 1'b0;
    logic [7:0] rdata_o;
    logic aen, ren, ext, wake_o, vector_o, hi, lo, irq_o;
    logic [3:0] tap;
    logic [3:0] lvl;
    logic [16:0] seed = 17'h111AC;
    logic rd_d = 1'b0;
    logic [7:0] exp_v;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    supply_level_detector #(.SETTLE_TICKS(2)) supply_level_detector_i (.core_clk_i, .rst_i,
        .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ref_tick_i(tick), .ref_shared_i(shared),
        .ref_ready_i(ready), .below_divider_i(below), .below_external_i(below_ext), .sleep_i,
        .analog_enable_o(aen), .reference_enable_o(ren), .external_select_o(ext),
        .tap_select_o(tap), .wake_o, .vector_o, .irq_high_o(hi), .irq_low_o(lo), .irq_o);
    always #4 core_clk_i = ~core_clk_i;
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // the expectation is queued as the read is issued
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk_i);
        rd_i <= 1'b0;
    endtask : rd
    // the tick is slow so the design's synchroniser sees every edge
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            tick <= 1'b1;
            idle(4);
            tick <= 1'b0;
            idle(4);
        end
    endtask : ticks
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // read data is valid only in the cycle after the strobe
    always @(posedge core_clk_i) begin
        rd_d <= rd_i;
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            `CHK(rdata_o, exp_v)
        end
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        idle(16);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
        seed = lfsr(seed);
        wr(3'h7, seed[7:0]);
        rd(3'h7, 8'h00);
        note("reset");
        wr(3'h0, 8'hFF);
        rd(3'h0, 8'h9F);
        `CHK({aen, ext}, 2'b11)
        lvl = (seed[3:0] == 4'hF) ? 4'hE : seed[3:0];
        wr(3'h0, {4'h1, lvl});
        below <= 1'b1;
        ready <= 1'b1;
        idle(10);
        rd(3'h2, 8'h00);
        rd(3'h0, {4'h1, lvl});
        ticks(3);
        idle(10);
        rd(3'h0, {4'h3, lvl});
        rd(3'h2, 8'h04);
        `CHK({ext, tap}, {1'b0, lvl})
        below <= 1'b0;
        idle(10);
        rd(3'h2, 8'h04);
        note("settle and trip");
        wr(3'h3, 8'h04);
        wr(3'h6, 8'h01);
        rd(3'h5, 8'h03);
        idle(3);
        `CHK({irq_o, hi, lo}, 3'b101)
        wr(3'h4, 8'h04);
        wr(3'h5, 8'h03);
        idle(3);
        `CHK({irq_o, hi, lo}, 3'b010)
        sleep_i <= 1'b1;
        idle(3);
        `CHK({wake_o, vector_o}, 2'b10)
        wr(3'h1, 8'h80);
        idle(3);
        `CHK(vector_o, 1'b1)
        sleep_i <= 1'b0;
        wr(3'h2, 8'h00);
        rd(3'h2, 8'h00);
        note("interrupts");
        wr(3'h0, {4'h9, lvl});
        idle(10);
        rd(3'h2, 8'h04);
        wr(3'h0, 8'h00);
        shared <= 1'b1;
        idle(3);
        `CHK({aen, ren}, 2'b01)
        wr(3'h0, 8'h1F);
        rd(3'h0, 8'h1F);
        note("direction and restart");
        wr(3'h2, 8'h00);
        below <= 1'b1;
        ticks(3);
        idle(10);
        rd(3'h2, 8'h00);
        below_ext <= 1'b1;
        idle(10);
        rd(3'h2, 8'h04);
        `CHK(ext, 1'b1)
        note("external input");
        idle(1);
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h3, 8'h00);
        idle(3);
        `CHK(exp_q.size(), 0)
        note("second reset");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
